// [bsw_top.v]
// Burst-of-four SRAM core: lane-masked writes, linear ordering, read forwarding
`timescale 1ns/1ps
`include "bsw_map.vh"

// Notes on behaviour
// R1: A lane is written only when its active-low strobe is low; others keep data.
// R2: Four byte strobes mask byte lanes; narrow variant uses two nibble strobes.
// R3: Strobes are sampled with every beat, on true and complementary edges alike.
// R4: Burst words one and three are captured on true-clock edges.
// R5: Burst words two and four are captured on complementary-clock edges.
// R6: A read right after a write to that address returns the new data.
// R7: Burst order counts up modulo four from the two low start bits.
// R8: Burst start bit inputs exist only on the wide variants; here BSW_START_EN gates them, not width.
// R9: A write in the second cycle after a read request is a no-op.
// R10: Without start bits every burst starts at word zero, ascending.

// ==========================================================
// Small FIFO, registered pointers, honest full and empty
module bsw_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] buf_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o  = buf_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge ref_clk_i) begin
    if (push) begin
      buf_q[wr_ptr_q] <= in_data_i;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==========================================================
// Top level
module bsw_top (
  // Clock and reset
  input  wire                       ref_clk_i,
  input  wire                       rst_n_i,
  // Request
  input  wire                       req_valid_i,
  input  wire                       req_read_i,
  input  wire [`BSW_ADDR_W-1:0]     addr_in_i,
  input  wire                       burst_start_bit_lo_i,
  input  wire                       burst_start_bit_hi_i,
  // Write beats
  input  wire                       beat_valid_i,
  input  wire                       beat_comp_edge_i,
  input  wire [`BSW_DATA_W-1:0]     beat_data_i,
  input  wire [`BSW_BYTE_LANES-1:0] byte_lane_write_n_i,
  input  wire [`BSW_NIB_LANES-1:0]  nibble_lane_write_n_i,
  // Read data
  output wire                       rd_valid_o,
  input  wire                       rd_ready_i,
  output wire [`BSW_DATA_W-1:0]     rd_data_o,
  // Status
  output wire                       wr_busy_o,
  output wire                       rd_busy_o,
  output wire                       nop_o,
  output wire                       beat_err_o
);
  reg  [`BSW_DATA_W-1:0] mem [0:(1<<`BSW_MEM_AW)-1];

  reg                    wr_busy_q;
  reg  [`BSW_ADDR_W-1:0] wr_addr_q;
  reg  [1:0]             wr_start_q;
  reg  [2:0]             wr_cnt_q;
  reg                    rd_busy_q;
  reg  [`BSW_ADDR_W-1:0] rd_addr_q;
  reg  [1:0]             rd_start_q;
  reg  [2:0]             rd_cnt_q;
  reg  [1:0]             rd_age_q;
  reg                    nop_q;
  reg                    beat_err_q;
  reg                    out_valid_q;
  reg  [`BSW_DATA_W-1:0] out_data_q;

  wire [1:0]             start_bits;
  wire                   wr_req;
  wire                   rd_req;
  wire                   beat_ok;
  wire [1:0]             wr_word;
  wire [1:0]             rd_word;
  wire [`BSW_DATA_W-1:0] bit_en;
  wire [`BSW_DATA_W-1:0] wr_old;
  wire                   fwd_wait;
  wire                   fifo_in_ready;
  wire                   fifo_out_valid;
  wire [`BSW_DATA_W-1:0] fifo_out_data;
  wire                   fifo_out_ready;
  wire                   rd_push;

  // Variants with BSW_START_EN at 0 have no start bits and always begin at word zero
  assign start_bits = (`BSW_START_EN != 0) ?
                      {burst_start_bit_hi_i, burst_start_bit_lo_i} : 2'h0; // [R8] [R10]
  assign wr_req     = req_valid_i & ~req_read_i & ~wr_busy_q & (rd_age_q != `BSW_NOP_AGE); // [R9]
  assign rd_req     = req_valid_i & req_read_i & ~rd_busy_q;

  // True edge for words one and three, complementary for two and four
  assign beat_ok    = beat_valid_i & wr_busy_q & (beat_comp_edge_i == wr_cnt_q[0]); // [R4] [R5]
  assign wr_word    = wr_start_q + wr_cnt_q[1:0]; // [R7]
  assign rd_word    = rd_start_q + rd_cnt_q[1:0]; // [R7]
  assign wr_old     = mem[{wr_addr_q, wr_word}];

  // Per-bit enable from the lane strobe that covers each bit
  genvar b;
  generate
    for (b = 0; b < `BSW_DATA_W; b = b + 1) begin : g_lane
      if (`BSW_NIBBLE_MODE != 0) begin : g_nib
        if (b < `BSW_NIB_LANES * `BSW_NIB_W) begin : g_in
          assign bit_en[b] = ~nibble_lane_write_n_i[b / `BSW_NIB_W]; // [R2] [R3]
        end else begin : g_out
          assign bit_en[b] = 1'b0;
        end
      end else begin : g_byte
        assign bit_en[b] = ~byte_lane_write_n_i[b / `BSW_BYTE_W]; // [R2] [R3]
      end
    end
  endgenerate

  // Masked lanes keep their old contents
  always @(posedge ref_clk_i) begin
    if (beat_ok) begin
      mem[{wr_addr_q, wr_word}] <= (wr_old & ~bit_en) | (beat_data_i & bit_en); // [R1]
    end
  end

  // ==========================================================
  // Write burst tracking
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_busy_q  <= 1'b0;
      wr_addr_q  <= {`BSW_ADDR_W{1'b0}};
      wr_start_q <= 2'h0;
      wr_cnt_q   <= 3'h0;
      beat_err_q <= 1'b0;
      nop_q      <= 1'b0;
      rd_age_q   <= 2'h0;
    end else begin
      beat_err_q <= beat_valid_i & ~beat_ok;
      nop_q      <= req_valid_i & ~req_read_i & (rd_age_q == `BSW_NOP_AGE); // [R9]
      if (rd_req) begin
        rd_age_q <= 2'h1;
      end else if (rd_age_q != 2'h0) begin
        rd_age_q <= (rd_age_q == `BSW_NOP_AGE) ? 2'h0 : rd_age_q + 2'h1;
      end
      if (wr_req) begin
        wr_busy_q  <= 1'b1;
        wr_addr_q  <= addr_in_i;
        wr_start_q <= start_bits;
        wr_cnt_q   <= 3'h0;
      end else if (beat_ok) begin
        wr_cnt_q <= wr_cnt_q + 3'h1;
        if (wr_cnt_q == `BSW_BURST_LEN - 3'h1) begin
          wr_busy_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Read engine; stalls behind an open write burst to the same address
  // so the freshly written words are what comes back
  assign fwd_wait = wr_busy_q & (wr_addr_q == rd_addr_q); // [R6]
  assign rd_push  = rd_busy_q & ~fwd_wait & fifo_in_ready;

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_busy_q  <= 1'b0;
      rd_addr_q  <= {`BSW_ADDR_W{1'b0}};
      rd_start_q <= 2'h0;
      rd_cnt_q   <= 3'h0;
    end else if (rd_req) begin
      rd_busy_q  <= 1'b1;
      rd_addr_q  <= addr_in_i;
      rd_start_q <= start_bits;
      rd_cnt_q   <= 3'h0;
    end else if (rd_push) begin
      rd_cnt_q <= rd_cnt_q + 3'h1;
      if (rd_cnt_q == `BSW_BURST_LEN - 3'h1) begin
        rd_busy_q <= 1'b0;
      end
    end
  end

  bsw_fifo #(
    .WIDTH (`BSW_DATA_W),
    .DEPTH (`BSW_FIFO_DEPTH),
    .AW    (`BSW_FIFO_AW)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rd_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem[{rd_addr_q, rd_word}]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ==========================================================
  // Output stage keeps every output on a flip-flop
  assign fifo_out_ready = ~out_valid_q | rd_ready_i;

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      out_valid_q <= 1'b0;
      out_data_q  <= {`BSW_DATA_W{1'b0}};
    end else if (fifo_out_ready) begin
      out_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        out_data_q <= fifo_out_data;
      end
    end
  end

  assign rd_valid_o = out_valid_q;
  assign rd_data_o  = out_data_q;
  assign wr_busy_o  = wr_busy_q;
  assign rd_busy_o  = rd_busy_q;
  assign nop_o      = nop_q;
  assign beat_err_o = beat_err_q;
endmodule

// [bsw_map.vh]
// Constants for the burst SRAM write-lane, ordering and forwarding block
`ifndef BSW_MAP_VH
`define BSW_MAP_VH

// ==========================================================
// Widths
`define BSW_DATA_W      36
`define BSW_ADDR_W      4
`define BSW_MEM_AW      6
`define BSW_BYTE_LANES  4
`define BSW_BYTE_W      9
`define BSW_NIB_LANES   2
`define BSW_NIB_W       4

// ==========================================================
// Variant options
`define BSW_NIBBLE_MODE 0
`define BSW_START_EN    1

// ==========================================================
// Burst shape and buffering
`define BSW_BURST_LEN   3'h4
`define BSW_FIFO_DEPTH  4
`define BSW_FIFO_AW     2
`define BSW_NOP_AGE     2'h2

`endif

// [bsw_props.sv]
// Port assertions for the burst SRAM core
`timescale 1ns/1ps
`include "bsw_map.vh"
module bsw_props (
  input wire                   ref_clk_i,
  input wire                   rst_n_i,
  input wire                   req_valid_i,
  input wire                   req_read_i,
  input wire                   beat_valid_i,
  input wire                   beat_comp_edge_i,
  input wire                   rd_valid_o,
  input wire                   rd_ready_i,
  input wire [`BSW_DATA_W-1:0] rd_data_o,
  input wire                   wr_busy_o,
  input wire                   rd_busy_o,
  input wire                   nop_o,
  input wire                   beat_err_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Read taken two edges back turns a write into a no-op
  reg  rt1_q;
  reg  rt2_q;
  wire rtake = req_valid_i & req_read_i & !rd_busy_o;
  wire wreq  = req_valid_i & !req_read_i & !wr_busy_o;
  always @(posedge ref_clk_i) begin
    rt1_q <= rst_n_i & rtake;
    rt2_q <= rst_n_i & rt1_q;
  end
  sequence wtake_s;
    wreq & !rt2_q;
  endsequence
  sequence burst_s;
    wtake_s ##1 (beat_valid_i & !beat_comp_edge_i) ##1 (beat_valid_i & beat_comp_edge_i)
      ##1 (beat_valid_i & !beat_comp_edge_i) ##1 (beat_valid_i & beat_comp_edge_i);
  endsequence
  wr_open_a: assert property (wtake_s |=> wr_busy_o) else $error("write not opened");
  burst_end_a: assert property (burst_s |-> wr_busy_o ##1 !wr_busy_o) else $error("burst length off");
  nop_drop_a: assert property (wreq & rt2_q |=> nop_o & !wr_busy_o ##1 !nop_o) else $error("no-op missed");
  nop_cause_a: assert property (nop_o |-> $past(wreq & rt2_q)) else $error("stray no-op");
  beat_stray_a: assert property (beat_valid_i & !wr_busy_o |=> beat_err_o) else $error("stray beat kept");
  err_cause_a: assert property (beat_err_o |-> $past(beat_valid_i)) else $error("error without beat");
  rd_open_a: assert property (rtake |=> rd_busy_o) else $error("read not opened");
  rd_hold_a: assert property (rd_valid_o & !rd_ready_i |=> rd_valid_o & $stable(rd_data_o))
    else $error("read word lost");
endmodule

// [bsw_ctrl_model.sv]
// Memory controller model: requests and write beats
`timescale 1ns/1ps
module bsw_ctrl_model (
  input  wire         ref_clk_i,
  output reg          rv_o,
  output reg          rr_o,
  output reg  [3:0]   ad_o,
  output reg  [1:0]   st_o,
  output reg          bv_o,
  output reg          be_o,
  output reg  [35:0]  bd_o,
  output reg  [3:0]   bw_o
);
  initial begin
    {rv_o, rr_o, bv_o, be_o, ad_o, st_o, bw_o} = 14'h0;
    bd_o = 36'h0;
  end
  // ==========================================================
  // One request cycle
  task req(input r, input [3:0] a, input [1:0] s);
    begin
      @(posedge ref_clk_i);
      rv_o <= 1'b1;
      rr_o <= r;
      ad_o <= a;
      st_o <= s;
      @(posedge ref_clk_i);
      rv_o <= 1'b0;
    end
  endtask
  // ==========================================================
  // Write request, then beats true,comp,true,comp; fr adds a read
  task wr(input [3:0] a, input [1:0] s, input [143:0] d, input [15:0] m, input fr);
    integer k;
    begin
      // Request inline so that rv_o gets one assignment per time step
      @(posedge ref_clk_i);
      rv_o <= 1'b1;
      rr_o <= 1'b0;
      ad_o <= a;
      st_o <= s;
      @(posedge ref_clk_i);
      for (k = 0; k < 4; k = k + 1) begin
        rv_o <= fr && k == 0;
        rr_o <= 1'b1;
        bv_o <= 1'b1;
        be_o <= k[0];
        bd_o <= d[36*k +: 36];
        bw_o <= m[4*k +: 4];
        @(posedge ref_clk_i);
      end
      rv_o <= 1'b0;
      bv_o <= 1'b0;
      // Released bus never shows the last word
      bd_o <= ~bd_o;
    end
  endtask
endmodule

// [burst_sram_write_lanes_bench.sv]
// Self-checking bench for the burst SRAM core
`timescale 1ns/1ps
module burst_sram_write_lanes_bench;
  reg         ref_clk_i;
  reg         rst_n_i;
  reg         rd_ready_i;
  wire        req_valid_i, req_read_i, beat_valid_i, beat_comp_edge_i;
  wire        rd_valid_o, wr_busy_o, rd_busy_o, nop_o, beat_err_o;
  wire [3:0]  addr_in_i, byte_lane_write_n_i;
  wire [1:0]  st;
  wire [35:0] beat_data_i, rd_data_o;
  reg  [35:0] mem [0:63];
  reg  [35:0] exp_q [$];
  reg  [31:0] seed, rnd;
  integer     n_errors, checks, nops, berrs, i, k, a;
  bsw_ctrl_model u_ctl (.ref_clk_i, .rv_o(req_valid_i), .rr_o(req_read_i), .ad_o(addr_in_i), .st_o(st),
    .bv_o(beat_valid_i), .be_o(beat_comp_edge_i), .bd_o(beat_data_i), .bw_o(byte_lane_write_n_i));
  bsw_top DUT (.ref_clk_i, .rst_n_i, .req_valid_i, .req_read_i, .addr_in_i, .burst_start_bit_lo_i(st[0]),
    .burst_start_bit_hi_i(st[1]), .beat_valid_i, .beat_comp_edge_i, .beat_data_i, .byte_lane_write_n_i,
    .nibble_lane_write_n_i(2'h3), .rd_valid_o, .rd_ready_i, .rd_data_o, .wr_busy_o, .rd_busy_o, .nop_o,
    .beat_err_o);
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task check(input [35:0] seen, input [35:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      if (n_errors == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Bounded wait until both sides are idle
  task idle;
    begin
      i = 0;
      do begin
        @(negedge ref_clk_i);
        i = i + 1;
      end while ((wr_busy_o | rd_busy_o) !== 1'b0 && i < 60);
      if (i >= 60) begin
        n_errors = n_errors + 1;
        give_verdict;
      end
    end
  endtask
  task rd_exp(input [3:0] ra, input [1:0] s);
    for (k = 0; k < 4; k = k + 1) exp_q.push_back(mem[{ra, s + k[1:0]}]);
  endtask
  task do_wr(input [3:0] wa, input [1:0] s, input [15:0] m, input fr);
    reg [159:0] d;
    begin
      for (k = 0; k < 5; k = k + 1) begin
        seed = xs(seed);
        d = {d[127:0], seed};
      end
      for (k = 0; k < 16; k = k + 1)
        if (!m[k]) mem[{wa, s + k[3:2]}][9*k[1:0] +: 9] = d[9*k +: 9];
      idle;
      if (fr) rd_exp(wa, s);
      u_ctl.wr(wa, s, d[143:0], m, fr);
    end
  endtask
  // ==========================================================
  // Clock, random consumer stalls, read monitor
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    rnd <= xs(rnd);
    rd_ready_i <= rnd[0] | rnd[5];
    if (nop_o === 1'b1) nops = nops + 1;
    if (beat_err_o === 1'b1) berrs = berrs + 1;
    if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
      if (exp_q.size() > 0) check(rd_data_o, exp_q.pop_front());
      else n_errors = n_errors + 1;
    end
  end
  initial begin
    rst_n_i = 1'b0;
    rd_ready_i = 1'b0;
    {n_errors, checks, nops, berrs} = 0;
    seed = 32'hc5da9ea8;
    rnd = seed;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (a = 0; a < 4; a = a + 1) do_wr(a, a, 16'h0, 1'b0);
    for (a = 0; a < 4; a = a + 1) begin
      do_wr(a, seed[1:0], seed[31:16], 1'b0);
      idle;
      rd_exp(a, 3 - a);
      u_ctl.req(1'b1, a, 3 - a);
    end
    do_wr(1, 2, seed[15:0], 1'b1);
    // Write two edges after a read: dropped, stray beats flagged
    idle;
    rd_exp(2, 1);
    u_ctl.req(1'b1, 2, 1);
    u_ctl.wr(2, 0, {4{seed, seed[3:0]}}, 16'h0, 1'b0);
    idle;
    rd_exp(2, 0);
    u_ctl.req(1'b1, 2, 0);
    i = 0;
    while (exp_q.size() > 0 && i < 300) begin
      @(negedge ref_clk_i);
      i = i + 1;
    end
    check(exp_q.size(), 0);
    check(nops, 1);
    // Four beats of the dropped write arrive with no burst open
    check(berrs, 4);
    give_verdict;
  end
endmodule
bind bsw_top bsw_props u_props (.ref_clk_i, .rst_n_i, .req_valid_i, .req_read_i, .beat_valid_i, .beat_comp_edge_i,
  .rd_valid_o, .rd_ready_i, .rd_data_o, .wr_busy_o, .rd_busy_o, .nop_o, .beat_err_o);
